//--- pkg/wdog_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDOG_REGS_SVH
`define WDOG_REGS_SVH
// ==================================================
// Register offsets on the CPU register port
`define WDOG_ADDR_STATUS 4'h0
`define WDOG_ADDR_DEBUG 4'h1
`define WDOG_ADDR_OPT1 4'h2
`define WDOG_ADDR_OPT2 4'h3
// ==================================================
// Service values written to the status address
`define WDOG_SVC_FIRST 8'h55
`define WDOG_SVC_SECOND 8'haa
// ==================================================
// Time-out select codes
`define WDOG_TSEL_OFF 2'h0
`define WDOG_TSEL_SHORT 2'h1
`define WDOG_TSEL_MID 2'h2
`define WDOG_TSEL_LONG 2'h3
// ==================================================
// Field positions and reset values
`define WDOG_OPT1_TSEL_MSB 7
`define WDOG_OPT1_TSEL_LSB 6
`define WDOG_OPT2_CLKS_BIT 7
`define WDOG_OPT2_WIN_BIT 6
`define WDOG_OPT_CLKS_RST 1'b0
`define WDOG_OPT_WIN_RST 1'b0
`define WDOG_SRS_ILLEGAL_BIT 3
`define WDOG_SRS_LV_BIT 1
`define WDOG_SRS_POR 8'h02
`define WDOG_DBG_FORCE_BIT 0
// ==================================================
// Timing: clock periods and overflow and window counts
`define WDOG_MCLK_PERIOD_NS 10
`define WDOG_LPO_PERIOD_NS 1000000
`define WDOG_LPO_TO_1 32
`define WDOG_LPO_TO_2 256
`define WDOG_LPO_TO_3 1024
`define WDOG_BUS_TO_1 8192
`define WDOG_BUS_TO_2 65536
`define WDOG_BUS_TO_3 262144
`define WDOG_BUS_WIN_1 6144
`define WDOG_BUS_WIN_2 49152
`define WDOG_BUS_WIN_3 196608
// Window opens with a quarter of the bus time-out left
`define WDOG_WIN_QUARTER_SHIFT 2
`endif

//--- pkg/wdog_pkg.sv
// Types shared by the watchdog modules
package wdog_pkg;
  // Service sequence tracker states
  typedef enum logic {SEQ_IDLE, SEQ_ARMED} seq_e;
  // Time-out select field
  typedef logic [1:0] tsel_t;
  // Watchdog count value
  typedef logic [17:0] wcount_t;
endpackage

//--- pkg/wdog_if.sv
// Signals between the watchdog control logic and its counter
`timescale 1ns/1ps
interface wdog_if;
  import wdog_pkg::*;
  logic tick;
  logic run;
  logic clear;
  wcount_t last;
  wcount_t count;
  logic expired;
  // Control side
  modport ctrl (output tick, output run, output clear, output last,
                input count, input expired);
  // Counter side
  modport cnt (input tick, input run, input clear, input last,
               output count, output expired);
endinterface

//--- verilog/wdog_counter.sv
// Watchdog overflow counter
`timescale 1ns/1ps
`include "wdog_regs.svh"
module wdog_counter
  import wdog_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control link
  wdog_if.cnt ifc
);
  wcount_t count_q;
  logic expired_q;
  wire at_last = (count_q == ifc.last);
  wire step = ifc.run && ifc.tick;

  // ==================================================
  // Count, wrap and overflow pulse
  always_ff @(posedge mclk) begin
    if (sys_rst || ifc.clear) begin
      count_q <= '0;
    end else if (step) begin
      count_q <= at_last ? '0 : count_q + 18'h1;
    end
  end

  always_ff @(posedge mclk) begin
    expired_q <= !sys_rst && !ifc.clear && step && at_last;
  end

  assign ifc.count = count_q;
  assign ifc.expired = expired_q;

  // ==================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  overflow_count_a: assert property (ifc.expired |-> $past(ifc.count) == $past(ifc.last))
    else $error("overflow not at selected count");
  clear_zero_a: assert property (ifc.clear |=> ifc.count == '0 && !ifc.expired)
    else $error("counter not cleared");
  stopped_quiet_a: assert property (!ifc.run |=> !ifc.expired)
    else $error("overflow while stopped");
endmodule // wdog_counter

//--- verilog/watchdog_and_reset_control.sv
// Watchdog, reset-cause status and debug-forced reset top module
`timescale 1ns/1ps
`include "wdog_regs.svh"
// ==================================================
// Notes on behaviour
// - Watchdog comes up enabled after every reset, no software step needed.
// - After reset: internal 1 kHz clock and longest time-out of 2^10 cycles.
// - Time-out select 00 disables the watchdog; it never expires then.
// - Writing 0x55 then 0xaa to status address restarts the time-out.
// - Status address writes only feed the service logic, never read contents.
// - Time-out expiry before a complete service raises a system reset.
// - Any other value written to the status address resets at once.
// - Clock select 0 counts the 1 kHz tick, 1 counts the bus clock.
// - 1 kHz overflow counts are 2^5, 2^8 and 2^10 ticks.
// - Bus overflow counts 2^13, 2^16, 2^18; windows open at 6144, 49152, 196608.
// - Bus clock with window set: service only in last quarter of period.
// - In windowed mode a service write before the window opens resets.
// - With the 1 kHz clock the window bit is ignored.
// - Status bit 3 reads 1 after an illegal address reset, else 0.
// - Status bit 1 reads 1 after power-on or enabled low-voltage reset.
// - Debug force register takes writes only from debug commands.
// - Debug force register always reads zero.
// - Debug write of 1 to the force bit resets the system.
module watchdog_and_reset_control
  import wdog_pkg::*;
#(
  parameter int LPO_DIV = `WDOG_LPO_PERIOD_NS / `WDOG_MCLK_PERIOD_NS,
  parameter int BUS_TO_1 = `WDOG_BUS_TO_1,
  parameter int BUS_TO_2 = `WDOG_BUS_TO_2,
  parameter int BUS_TO_3 = `WDOG_BUS_TO_3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // CPU register access
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_dbg,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Reset causes from system logic
  input wire logic por_event,
  input wire logic lv_event,
  input wire logic low_voltage_reset_enable,
  input wire logic illegal_address_event,
  // System reset request
  output logic reset_req
);
  localparam int LPO_W = (LPO_DIV > 1) ? $clog2(LPO_DIV) : 1;
  // Window opening counts follow the time-outs, last quarter left
  localparam int BUS_WIN_1 = BUS_TO_1 - (BUS_TO_1 >> `WDOG_WIN_QUARTER_SHIFT);
  localparam int BUS_WIN_2 = BUS_TO_2 - (BUS_TO_2 >> `WDOG_WIN_QUARTER_SHIFT);
  localparam int BUS_WIN_3 = BUS_TO_3 - (BUS_TO_3 >> `WDOG_WIN_QUARTER_SHIFT);

  // ==================================================
  // State
  tsel_t timeout_select_q;
  logic watchdog_clock_select_q;
  logic window_enable_q;
  logic [7:0] status_q;
  logic [7:0] rdata_q;
  logic reset_req_q;
  logic lpo_tick_q;
  logic [LPO_W-1:0] lpo_cnt_q;
  seq_e seq_q;
  seq_e seq_d;

  wdog_if ifc ();

  // ==================================================
  // Register decode
  wire status_wr = cpu_wr && (cpu_addr == `WDOG_ADDR_STATUS);
  wire debug_wr = cpu_wr && (cpu_addr == `WDOG_ADDR_DEBUG);
  wire opt1_wr = cpu_wr && (cpu_addr == `WDOG_ADDR_OPT1);
  wire opt2_wr = cpu_wr && (cpu_addr == `WDOG_ADDR_OPT2);
  wire tsel_t tsel_wdata = cpu_wdata[`WDOG_OPT1_TSEL_MSB:`WDOG_OPT1_TSEL_LSB];
  wire clks_wdata = cpu_wdata[`WDOG_OPT2_CLKS_BIT];
  wire win_wdata = cpu_wdata[`WDOG_OPT2_WIN_BIT];

  // Service value classification
  wire svc_first = status_wr && (cpu_wdata == `WDOG_SVC_FIRST);
  wire svc_second = status_wr && (cpu_wdata == `WDOG_SVC_SECOND);
  wire bad_value = status_wr && !svc_first && !svc_second;

  // ==================================================
  // Mode decode
  wire wd_on = (timeout_select_q != `WDOG_TSEL_OFF);
  wire win_eff = watchdog_clock_select_q && window_enable_q;

  // Overflow last count for the 1 kHz source
  wire wcount_t lpo_last =
    (timeout_select_q == `WDOG_TSEL_SHORT) ? 18'(`WDOG_LPO_TO_1 - 1) :
    (timeout_select_q == `WDOG_TSEL_MID) ? 18'(`WDOG_LPO_TO_2 - 1) :
    18'(`WDOG_LPO_TO_3 - 1);

  // Overflow last count for the bus clock
  wire wcount_t bus_last =
    (timeout_select_q == `WDOG_TSEL_SHORT) ? 18'(BUS_TO_1 - 1) :
    (timeout_select_q == `WDOG_TSEL_MID) ? 18'(BUS_TO_2 - 1) :
    18'(BUS_TO_3 - 1);

  // Count at which the service window opens
  wire wcount_t win_open =
    (timeout_select_q == `WDOG_TSEL_SHORT) ? 18'(BUS_WIN_1) :
    (timeout_select_q == `WDOG_TSEL_MID) ? 18'(BUS_WIN_2) :
    18'(BUS_WIN_3);

  // Early service write while windowed
  wire early = win_eff && wd_on && (svc_first || svc_second) &&
               (ifc.count < win_open);

  // Debug-only force reset
  wire dbg_force = debug_wr && cpu_dbg && cpu_wdata[`WDOG_DBG_FORCE_BIT];

  // ==================================================
  // Reset events
  wire lv_reset = lv_event && low_voltage_reset_enable;
  wire ext_reset = por_event || lv_reset || illegal_address_event;
  wire rst_evt = reset_req_q || ext_reset;
  wire fire = ifc.expired || bad_value || early || dbg_force;

  // Completed service and setting changes
  wire svc_done = svc_second && (seq_q == SEQ_ARMED) && !early;
  wire cfg_chg = (opt1_wr && (tsel_wdata != timeout_select_q)) ||
                 (opt2_wr && (clks_wdata != watchdog_clock_select_q));

  // ==================================================
  // Counter control
  assign ifc.run = wd_on;
  assign ifc.tick = watchdog_clock_select_q ? 1'b1 : lpo_tick_q;
  assign ifc.last = watchdog_clock_select_q ? bus_last : lpo_last;
  assign ifc.clear = rst_evt || svc_done || cfg_chg;

  wdog_counter u_counter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ifc(ifc.cnt)
  );

  // ==================================================
  // Internal 1 kHz tick from the bus clock
  wire lpo_wrap = (lpo_cnt_q == LPO_W'(LPO_DIV - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lpo_cnt_q <= '0;
    end else begin
      lpo_cnt_q <= lpo_wrap ? '0 : lpo_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    lpo_tick_q <= !sys_rst && lpo_wrap;
  end

  // ==================================================
  // Watchdog options, defaults restored on every reset
  always_ff @(posedge mclk) begin
    if (sys_rst || rst_evt) begin
      timeout_select_q <= `WDOG_TSEL_LONG;
    end else if (opt1_wr) begin
      timeout_select_q <= tsel_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || rst_evt) begin
      watchdog_clock_select_q <= `WDOG_OPT_CLKS_RST;
      window_enable_q <= `WDOG_OPT_WIN_RST;
    end else if (opt2_wr) begin
      watchdog_clock_select_q <= clks_wdata;
      window_enable_q <= win_wdata;
    end
  end

  // ==================================================
  // Service sequence tracker
  always_comb begin
    seq_d = seq_q;
    unique case (seq_q)
      SEQ_IDLE: begin
        if (svc_first && !early) begin
          seq_d = SEQ_ARMED;
        end
      end
      SEQ_ARMED: begin
        if (svc_second || early) begin
          seq_d = SEQ_IDLE;
        end
      end
    endcase
    if (rst_evt || cfg_chg) begin
      seq_d = SEQ_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seq_q <= SEQ_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // ==================================================
  // Reset request pulse
  always_ff @(posedge mclk) begin
    reset_req_q <= !sys_rst && fire;
  end

  assign reset_req = reset_req_q;

  // ==================================================
  // Reset cause status, loaded only by reset events
  wire [7:0] cause_d = (8'(illegal_address_event) << `WDOG_SRS_ILLEGAL_BIT) |
                       (8'(por_event || lv_reset) << `WDOG_SRS_LV_BIT);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_q <= `WDOG_SRS_POR;
    end else if (rst_evt) begin
      status_q <= cause_d;
    end
  end

  // ==================================================
  // Read data selection
  wire [7:0] opt1_rd = 8'(timeout_select_q) << `WDOG_OPT1_TSEL_LSB;
  wire [7:0] opt2_rd = (8'(watchdog_clock_select_q) << `WDOG_OPT2_CLKS_BIT) |
                       (8'(window_enable_q) << `WDOG_OPT2_WIN_BIT);
  wire [7:0] rd_mux =
    (cpu_addr == `WDOG_ADDR_STATUS) ? status_q :
    (cpu_addr == `WDOG_ADDR_OPT1) ? opt1_rd :
    (cpu_addr == `WDOG_ADDR_OPT2) ? opt2_rd :
    8'h00;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (cpu_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign cpu_rdata = rdata_q;

  // ==================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Status address write of neither service value
  sequence s_bad_write;
    bad_value;
  endsequence

  // Armed tracker then a good second value
  sequence s_service_pair;
    (seq_q == SEQ_ARMED) && svc_second && !early;
  endsequence

  // A request and then the defaults in force
  sequence s_reset_then_defaults;
    reset_req_q ##1 (timeout_select_q == `WDOG_TSEL_LONG) && !watchdog_clock_select_q;
  endsequence

  bad_value_reset_a: assert property (s_bad_write |=> reset_req_q)
    else $error("bad service value did not reset");
  service_restart_a: assert property (s_service_pair |=> ifc.count == '0 && !reset_req_q)
    else $error("service pair did not restart count");
  reset_defaults_a: assert property (reset_req_q |-> s_reset_then_defaults)
    else $error("defaults not restored after reset");
  defaults_lpo_a: assert property (rst_evt |=> ifc.last == 18'(`WDOG_LPO_TO_3 - 1) && ifc.run)
    else $error("default time-out not longest");
  early_write_a: assert property (early |=> reset_req_q)
    else $error("premature service did not reset");
  expiry_reset_a: assert property (ifc.expired |=> reset_req_q)
    else $error("expiry did not reset");
  status_write_a: assert property (status_wr && !rst_evt |=> $stable(status_q))
    else $error("status changed by write");
  lpo_no_window_a: assert property (!watchdog_clock_select_q && wd_on && svc_first
                                    |=> !reset_req_q || $past(ifc.expired))
    else $error("window applied on 1 kHz clock");
  illegal_cause_a: assert property (illegal_address_event |=> status_q[`WDOG_SRS_ILLEGAL_BIT])
    else $error("illegal address cause not recorded");
  power_cause_a: assert property (por_event |=> status_q[`WDOG_SRS_LV_BIT])
    else $error("power-on cause not recorded");
  dbg_user_a: assert property (debug_wr && !cpu_dbg && !ifc.expired |=> !reset_req_q)
    else $error("user write forced a reset");
  dbg_read_a: assert property (cpu_rd && cpu_addr == `WDOG_ADDR_DEBUG |=> cpu_rdata == 8'h00)
    else $error("debug register read not zero");
  dbg_force_a: assert property (dbg_force |=> reset_req_q)
    else $error("debug force did not reset");
endmodule // watchdog_and_reset_control

//--- testbench/reset_cause_source.sv
// Model of the system reset logic around the watchdog block
`timescale 1ns/1ps
// ==================================================
// Reset cause source and reset request observer
module reset_cause_source (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Reset request from the block
  input wire logic reset_req,
  // Reset cause pulses
  output logic por_event,
  output logic lv_event,
  output logic illegal_address_event
);
  int req_total;
  // Causes rest low between pulses
  initial begin
    por_event = 1'b0;
    lv_event = 1'b0;
    illegal_address_event = 1'b0;
    req_total = 0;
  end
  // Count system reset requests taken by the system
  always @(posedge mclk) begin
    if (!sys_rst && reset_req === 1'b1) begin
      req_total++;
    end
  end
  // One-cycle cause pulse: 0 power-on, 1 low voltage, 2 illegal address
  task automatic pulse(input int kind);
    @(posedge mclk);
    #1;
    por_event = (kind == 0);
    lv_event = (kind == 1);
    illegal_address_event = (kind == 2);
    @(posedge mclk);
    #1;
    por_event = 1'b0;
    lv_event = 1'b0;
    illegal_address_event = 1'b0;
  endtask
endmodule // reset_cause_source

//--- testbench/tb.sv
// Self-checking testbench of the watchdog and reset control block
`timescale 1ns/1ps
`include "wdog_regs.svh"
module tb;
  import wdog_pkg::*;
  localparam int DIV = 4;
  int bus_to[1:3] = '{64, 128, 256};
  int lpo_to[1:3] = '{`WDOG_LPO_TO_1, `WDOG_LPO_TO_2, `WDOG_LPO_TO_3};
  logic mclk, sys_rst, cpu_wr, cpu_rd, cpu_dbg, low_voltage_reset_enable, reset_req;
  logic por_event, lv_event, illegal_address_event, last_req;
  logic [3:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, rd_val;
  int mismatches, check_count;
  // ==================================================
  // Block under test and its far side
  watchdog_and_reset_control #(.LPO_DIV(DIV), .BUS_TO_1(64), .BUS_TO_2(128), .BUS_TO_3(256))
    dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_dbg(cpu_dbg),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .por_event(por_event), .lv_event(lv_event),
    .low_voltage_reset_enable(low_voltage_reset_enable),
    .illegal_address_event(illegal_address_event), .reset_req(reset_req));
  reset_cause_source src_u (.mclk(mclk), .sys_rst(sys_rst), .reset_req(reset_req),
    .por_event(por_event), .lv_event(lv_event), .illegal_address_event(illegal_address_event));
  // ==================================================
  // Bus cycles and comparisons
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic dbg = 1'b0);
    @(posedge mclk);
    #1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_dbg = dbg;
    cpu_wr = 1'b1;
    @(posedge mclk);
    #1;
    last_req = reset_req;
    cpu_wr = 1'b0;
    cpu_dbg = 1'b0;
  endtask
  task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(posedge mclk);
    #1;
    cpu_rd = 1'b0;
    chk8(what, exp, cpu_rdata);
  endtask
  // Waits for a reset request, expecting it between lo and hi cycles
  task automatic chk_req(input string what, input int lo, input int hi);
    int n;
    n = 0;
    while (reset_req !== 1'b1 && n <= hi) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check_count++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
    repeat (2) @(posedge mclk);
  endtask
  // No reset request during n cycles
  task automatic quiet(input string what, input int n);
    int c;
    c = src_u.req_total;
    repeat (n) @(posedge mclk);
    #1;
    chk8(what, 8'h00, 8'(src_u.req_total - c));
  endtask
  task automatic service();
    wr(`WDOG_ADDR_STATUS, `WDOG_SVC_FIRST);
    wr(`WDOG_ADDR_STATUS, `WDOG_SVC_SECOND);
  endtask
  // ==================================================
  // Scenarios
  task automatic t_defaults();
    rd("status", `WDOG_ADDR_STATUS, `WDOG_SRS_POR);
    rd("opt1", `WDOG_ADDR_OPT1, 8'hc0);
    rd("opt2", `WDOG_ADDR_OPT2, 8'h00);
    rd("debug", `WDOG_ADDR_DEBUG, 8'h00);
    rd("unmapped", 4'h7, 8'h00);
    $display("defaults done");
  endtask
  task automatic t_service();
    for (int i = 0; i < 5; i++) begin
      quiet("svc quiet", 1500);
      service();
    end
    rd("status kept", `WDOG_ADDR_STATUS, `WDOG_SRS_POR);
    $display("service done");
  endtask
  task automatic t_bad();
    wr(`WDOG_ADDR_STATUS, 8'h12);
    chk8("bad value req", 8'h01, {7'h00, last_req});
    rd("status wd", `WDOG_ADDR_STATUS, 8'h00);
    rd("opt1 again", `WDOG_ADDR_OPT1, 8'hc0);
    $display("bad value done");
  endtask
  task automatic t_bus_to();
    for (int i = 1; i <= 3; i++) begin
      wr(`WDOG_ADDR_OPT2, 8'h80);
      wr(`WDOG_ADDR_OPT1, 8'(i << 6));
      chk_req("bus expiry", bus_to[i] - 2, bus_to[i] + 4);
    end
    $display("bus timeouts done");
  endtask
  task automatic t_lpo_to();
    for (int i = 1; i <= 3; i++) begin
      wr(`WDOG_ADDR_OPT2, (i == 1) ? 8'h40 : 8'h00);
      wr(`WDOG_ADDR_OPT1, 8'(i << 6));
      if (i == 1) begin
        service();
        chk8("early svc lpo", 8'h00, {7'h00, last_req});
      end
      chk_req("lpo expiry", lpo_to[i] * DIV - 2 * DIV - 8, lpo_to[i] * DIV + DIV + 4);
    end
    $display("slow clock timeouts done");
  endtask
  task automatic t_window();
    wr(`WDOG_ADDR_OPT2, 8'hc0);
    wr(`WDOG_ADDR_OPT1, 8'h40);
    repeat (20) @(posedge mclk);
    wr(`WDOG_ADDR_STATUS, `WDOG_SVC_FIRST);
    chk8("premature req", 8'h01, {7'h00, last_req});
    repeat (2) @(posedge mclk);
    wr(`WDOG_ADDR_OPT2, 8'hc0);
    wr(`WDOG_ADDR_OPT1, 8'h40);
    quiet("before window", 52);
    service();
    chk8("in window req", 8'h00, {7'h00, last_req});
    chk_req("restart", 62, 68);
    $display("window done");
  endtask
  task automatic t_setting();
    wr(`WDOG_ADDR_OPT2, 8'h80);
    wr(`WDOG_ADDR_OPT1, 8'h40);
    repeat (40) @(posedge mclk);
    wr(`WDOG_ADDR_OPT1, 8'h80);
    chk_req("cleared on change", 126, 132);
    $display("setting change done");
  endtask
  task automatic t_disabled();
    wr(`WDOG_ADDR_OPT2, 8'hc0);
    wr(`WDOG_ADDR_OPT1, 8'h00);
    service();
    quiet("disabled", 600);
    wr(`WDOG_ADDR_STATUS, 8'h33);
    chk8("bad when off", 8'h01, {7'h00, last_req});
    $display("disabled done");
  endtask
  task automatic t_debug();
    wr(`WDOG_ADDR_DEBUG, 8'h01, 1'b0);
    quiet("user force", 4);
    rd("debug read", `WDOG_ADDR_DEBUG, 8'h00);
    wr(`WDOG_ADDR_DEBUG, 8'h01, 1'b1);
    chk8("debug force", 8'h01, {7'h00, last_req});
    rd("status dbg", `WDOG_ADDR_STATUS, 8'h00);
    $display("debug done");
  endtask
  task automatic t_causes();
    src_u.pulse(2);
    rd("illegal", `WDOG_ADDR_STATUS, 8'h08);
    wr(`WDOG_ADDR_OPT1, 8'h40);
    low_voltage_reset_enable = 1'b0;
    src_u.pulse(1);
    rd("lv off", `WDOG_ADDR_STATUS, 8'h08);
    rd("opt kept", `WDOG_ADDR_OPT1, 8'h40);
    low_voltage_reset_enable = 1'b1;
    src_u.pulse(1);
    rd("lv on", `WDOG_ADDR_STATUS, 8'h02);
    src_u.pulse(2);
    src_u.pulse(0);
    rd("power on", `WDOG_ADDR_STATUS, 8'h02);
    $display("causes done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==================================================
  // Clock, main sequence and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    cpu_addr = 4'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_dbg = 1'b0;
    cpu_wdata = 8'h00;
    low_voltage_reset_enable = 1'b0;
    last_req = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    t_defaults();
    t_service();
    t_bad();
    t_bus_to();
    t_lpo_to();
    t_window();
    t_setting();
    t_disabled();
    t_debug();
    t_causes();
    report_and_stop();
  end
  initial begin
    #600000;
    mismatches++;
    report_and_stop();
  end
endmodule // tb
